/* inc/reset_seq_pkg.sv */
// Constants for the reset supply monitor sequencer.
// Assumes a single 20 MHz clock; supply comparator levels arrive asynchronously.
// Overview of operation
// [R1] Three causes each force the controller into reset
// [R2] External clear pin low holds reset
// [R3] Power-up reset held until supply above threshold
// [R4] Hold reset power-up hold time after threshold
// [R5] Supply at or below drop level forces reset
// [R6] Hold reset drop hold time after recovery
// [R7] Dips of at least 200 us reset
// [R8] Boot finishes within 500 to 710 ms
// [R9] All timing derived from main clock
// [R10] Board keeps crystal settling under 20 ms
// [R11] Driver holds pin low 2 ms/200 us
// [R12] Release only when all sources idle, timers expired
package reset_seq_pkg;
    localparam int CLK_HZ              = 20_000_000;
    localparam int HOLD_US             = 4600;
    localparam int DIP_US              = 200;
    localparam int BOOT_MIN_MS         = 500;
    localparam int BOOT_MAX_MS         = 710;
    // Least times use whole cycles per us, truncated
    localparam int HOLD_CYCLES         = (HOLD_US * (CLK_HZ / 1_000_000) + 0);
    localparam int DIP_CYCLES          = (DIP_US * (CLK_HZ / 1_000_000));
    localparam int BOOT_MIN_CYCLES     = BOOT_MIN_MS * (CLK_HZ / 1000);
    localparam int BOOT_MAX_CYCLES     = BOOT_MAX_MS * (CLK_HZ / 1000);
    localparam int CNT_W               = 24;
    localparam logic [CNT_W-1:0] CNT_RESET = 24'h000000;
endpackage

/* core/hold_timer.sv */
// Hold timer: counts while idle, restarts whenever its cause is active.
// Assumes cause is synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module hold_timer
#(
    parameter int LIMIT = 92000,
    parameter int W     = 24
)
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Cause and result
    input  wire logic cause,
    output logic      expired
);
    logic [W-1:0] count;
    logic [W-1:0] next_count;

    always_comb
    begin
        next_count = count;
        if (cause)
            next_count = '0;
        else if (count != W'(LIMIT))
            next_count = count + W'(1);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            count <= '0;
        else
            count <= next_count;
    end

    assign expired = (count == W'(LIMIT)) && !cause;
endmodule
`default_nettype wire

/* core/reset_supply_monitor_sequencer.sv */
// Reset sequencer: merges external pin, power-up and supply-drop causes.
// Assumes comparator outputs and pin are asynchronous; boot_done comes from firmware logic on clk.
`timescale 1ns/1ps
`default_nettype none
module reset_supply_monitor_sequencer
    import reset_seq_pkg::*;
#(
    parameter int HOLD_LEN     = reset_seq_pkg::HOLD_CYCLES,
    parameter int DIP_LEN      = reset_seq_pkg::DIP_CYCLES,
    parameter int BOOT_MIN_LEN = reset_seq_pkg::BOOT_MIN_CYCLES,
    parameter int BOOT_MAX_LEN = reset_seq_pkg::BOOT_MAX_CYCLES
)
(
    // Clock and power-on reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Reset causes
    input  wire logic external_clear_pin_n,
    input  wire logic power_up_threshold,
    input  wire logic supply_drop_monitor,
    // Boot handshake
    input  wire logic card_used,
    input  wire logic boot_done,
    // Results
    output logic      core_reset_n,
    output logic      ready,
    output logic      boot_timeout
);
    import reset_seq_pkg::*;

    // =====================================================
    // Input synchronisers
    logic [1:0] pin_sync;
    logic [1:0] por_sync;
    logic [1:0] drop_sync;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_sync  <= 2'h0;
            por_sync  <= 2'h0;
            drop_sync <= 2'h3;
        end
        else
        begin
            pin_sync  <= {pin_sync[0], external_clear_pin_n}; // R12
            por_sync  <= {por_sync[0], power_up_threshold};
            drop_sync <= {drop_sync[0], supply_drop_monitor};
        end
    end

    logic pin_low;
    logic below_por;
    logic drop_raw;
    assign pin_low   = !pin_sync[1]; // R2
    assign below_por = !por_sync[1]; // R3
    assign drop_raw  = drop_sync[1];

    // =====================================================
    // Dip qualification: a drop counts once it lasts the minimum time
    logic [CNT_W-1:0] dip_count;
    logic [CNT_W-1:0] next_dip_count;
    logic             drop_latched;
    logic             next_drop_latched;

    always_comb
    begin
        next_dip_count    = dip_count;
        next_drop_latched = drop_latched;
        if (!drop_raw)
        begin
            next_dip_count    = CNT_RESET;
            next_drop_latched = 1'b0;
        end
        else if (dip_count != CNT_W'(DIP_LEN - 1))
            next_dip_count = dip_count + CNT_W'(1);
        else
            next_drop_latched = 1'b1; // R7 R5
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dip_count    <= CNT_RESET;
            drop_latched <= 1'b0;
        end
        else
        begin
            dip_count    <= next_dip_count;
            drop_latched <= next_drop_latched;
        end
    end

    // =====================================================
    // Hold timers, clocked by main clock
    logic por_expired;
    logic drop_expired;
    logic drop_cause;
    // Once a qualified dip is seen, hold it until supply is back
    assign drop_cause = drop_latched;

    hold_timer #(.LIMIT(HOLD_LEN), .W(CNT_W)) u_por_hold
    (
        .clk     (clk),
        .rst_n   (rst_n),
        .cause   (below_por), // R4 R9
        .expired (por_expired)
    );

    hold_timer #(.LIMIT(HOLD_LEN), .W(CNT_W)) u_drop_hold
    (
        .clk     (clk),
        .rst_n   (rst_n),
        .cause   (drop_cause), // R6
        .expired (drop_expired)
    );

    // =====================================================
    // Internal reset combine
    logic next_core_reset_n;
    assign next_core_reset_n = !pin_low && por_expired && drop_expired; // R1 R12

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            core_reset_n <= 1'b0;
        else
            core_reset_n <= next_core_reset_n;
    end

    // =====================================================
    // Boot supervision after release
    typedef enum logic [1:0] {ST_RESET, ST_BOOT, ST_READY, ST_FAIL} boot_state_e;
    boot_state_e      state;
    boot_state_e      next_state;
    logic [CNT_W-1:0] boot_count;
    logic [CNT_W-1:0] next_boot_count;
    logic [CNT_W-1:0] boot_limit;

    // Longer bound only when a card must be scanned
    assign boot_limit = card_used ? CNT_W'(BOOT_MAX_LEN) : CNT_W'(BOOT_MIN_LEN); // R8

    always_comb
    begin
        next_state      = state;
        next_boot_count = boot_count;
        if (!core_reset_n)
        begin
            next_state      = ST_RESET;
            next_boot_count = CNT_RESET;
        end
        else
        begin
            unique case (state)
                ST_RESET: next_state = ST_BOOT;
                ST_BOOT:
                begin
                    next_boot_count = boot_count + CNT_W'(1);
                    if (boot_done)
                        next_state = ST_READY;
                    else if (boot_count >= boot_limit - CNT_W'(1))
                        next_state = ST_FAIL; // R8
                end
                ST_READY: next_state = ST_READY;
                ST_FAIL:  next_state = ST_FAIL;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state      <= ST_RESET;
            boot_count <= CNT_RESET;
        end
        else
        begin
            state      <= next_state;
            boot_count <= next_boot_count;
        end
    end

    // Gated so both drop in the same cycle as the internal reset
    assign ready        = (state == ST_READY) && core_reset_n;
    assign boot_timeout = (state == ST_FAIL) && core_reset_n;

    // =====================================================
    // Checks
    AST_PIN_RESET: assert property (@(posedge clk) disable iff (!rst_n) // R2
        pin_low |=> !core_reset_n)
        else $error("core reset not asserted with pin low");
    AST_POR_RESET: assert property (@(posedge clk) disable iff (!rst_n) // R3
        below_por |=> !core_reset_n)
        else $error("core reset released below power-up threshold");
    AST_DROP_RESET: assert property (@(posedge clk) disable iff (!rst_n) // R5
        drop_latched |=> !core_reset_n)
        else $error("core reset released during supply drop");
    AST_POR_HOLD: assert property (@(posedge clk) disable iff (!rst_n) // R4
        $fell(below_por) |-> !core_reset_n [*8])
        else $error("power-up hold too short");
    AST_DIP_SHORT: assert property (@(posedge clk) disable iff (!rst_n) // R7
        $rose(drop_raw) |-> !drop_latched [*8])
        else $error("dip qualified too early");
    AST_DROP_HOLD: assert property (@(posedge clk) disable iff (!rst_n) // R6
        $fell(drop_latched) |-> !core_reset_n [*8])
        else $error("drop hold too short");
    AST_RELEASE_ALL: assert property (@(posedge clk) disable iff (!rst_n) // R12 R1
        core_reset_n |-> !$past(pin_low) && $past(por_expired) && $past(drop_expired))
        else $error("release without all sources idle");
    AST_BOOT_BOUND: assert property (@(posedge clk) disable iff (!rst_n) // R8
        (state == ST_BOOT) |-> (boot_count < boot_limit))
        else $error("boot count beyond limit");
    AST_READY_ONLY_RUN: assert property (@(posedge clk) disable iff (!rst_n) // R2
        ready |-> core_reset_n)
        else $error("ready while in reset");
    AST_DIP_QUALIFY: assert property (@(posedge clk) disable iff (!rst_n) // R7
        (drop_raw && (dip_count == CNT_W'(DIP_LEN - 1))) |=> drop_latched)
        else $error("long dip not qualified");
    AST_READY_TIMEOUT_EXCL: assert property (@(posedge clk) disable iff (!rst_n) // R8
        !(ready && boot_timeout))
        else $error("ready and boot timeout together");
endmodule
`default_nettype wire

/* sim/supply_partner_model.sv */
// Far-side model: external clear driver and the supply comparators.
// Assumes the bench calls its tasks; all levels change at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module supply_partner_model
(
    // Clock
    input  wire logic clk,
    // Levels toward the sequencer
    output logic      external_clear_pin_n,
    output logic      power_up_threshold,
    output logic      supply_drop_monitor
);
    // ==========================================
    // Power-off start: supply not yet up
    initial
    begin
        external_clear_pin_n = 1'b1;
        power_up_threshold   = 1'b0;
        supply_drop_monitor  = 1'b0;
    end

    // Pulse holds the pin low for n clock cycles; no driver minimum enforced
    task pin_pulse(input int n);
        @(negedge clk) external_clear_pin_n = 1'b0;
        repeat (n) @(negedge clk);
        external_clear_pin_n = 1'b1;
    endtask

    task dip(input int n);
        @(negedge clk) supply_drop_monitor = 1'b1;
        repeat (n) @(negedge clk);
        supply_drop_monitor = 1'b0;
    endtask

    task power_good();
        @(negedge clk) power_up_threshold = 1'b1;
    endtask
endmodule
`default_nettype wire

/* sim/reset_supply_monitor_sequencer_tb_top.sv */
// Bench for the reset sequencer with short hold and boot counts.
// Assumes the partner model drives all reset causes.
`timescale 1ns/1ps
`default_nettype none
module reset_supply_monitor_sequencer_tb_top;
    import reset_seq_pkg::*;
    localparam int HL = 20, DL = 10, BMIN = 50, BMAX = 80;
    logic clk = 1'b0, rst_n = 1'b0, card_used = 1'b0, boot_done = 1'b0;
    wire logic pin_n, por_ok, drop, core_reset_n, ready, boot_timeout;
    int n_mismatch = 0, num_checks = 0, cyc = 0, n;
    logic seen;

    // ==========================================
    // Clock, instances, hang guard
    always #25 clk = ~clk;
    supply_partner_model supply_partner_model_i (.clk(clk), .external_clear_pin_n(pin_n),
        .power_up_threshold(por_ok), .supply_drop_monitor(drop));
    reset_supply_monitor_sequencer #(.HOLD_LEN(HL), .DIP_LEN(DL), .BOOT_MIN_LEN(BMIN), .BOOT_MAX_LEN(BMAX))
    reset_supply_monitor_sequencer_i (.clk(clk), .rst_n(rst_n), .external_clear_pin_n(pin_n),
        .power_up_threshold(por_ok), .supply_drop_monitor(drop), .card_used(card_used),
        .boot_done(boot_done), .core_reset_n(core_reset_n), .ready(ready), .boot_timeout(boot_timeout));
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            n_mismatch++;
            results();
        end
    end

    // ==========================================
    // Shared helpers
    task chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task wait_rel(output int c);
        c = 0;
        while (core_reset_n !== 1'b1 && c < 200)
        begin
            @(negedge clk);
            c++;
        end
    endtask
    task watch_low(input int c, output logic s);
        s = 1'b0;
        repeat (c)
        begin
            @(negedge clk);
            if (core_reset_n !== 1'b1) s = 1'b1;
        end
    endtask
    task results();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ==========================================
    // Scenarios
    task t_por();
        repeat (30) @(negedge clk);
        chk("held before supply up", core_reset_n, 1'b0);
        supply_partner_model_i.power_good();
        wait_rel(n);
        chk("power-up hold", (n >= HL && n <= HL + 8), 1'b1);
        $display("test power-up done");
    endtask
    task t_boot(input logic card, input int lim);
        card_used = card;
        fork
            supply_partner_model_i.pin_pulse(HL);
            begin
                repeat (6) @(negedge clk);
                chk("pin holds reset", core_reset_n, 1'b0);
            end
        join
        wait_rel(n);
        chk("release after pin", (n <= HL + 8), 1'b1);
        n = 0;
        while (boot_timeout !== 1'b1 && n < BMAX + 20)
        begin
            @(negedge clk);
            n++;
        end
        chk("boot bound", (n >= lim - 3 && n <= lim + 5), 1'b1);
        chk("not ready", ready, 1'b0);
        $display("test boot bound done");
    endtask
    task t_dip();
        fork
            supply_partner_model_i.dip(DL - 4);
            watch_low(DL + 8, seen);
        join
        chk("short dip ignored", seen, 1'b0);
        fork
            supply_partner_model_i.dip(DL + 4);
            watch_low(DL + 4, seen);
        join
        chk("long dip resets", seen, 1'b1);
        wait_rel(n);
        chk("drop hold", (n >= HL && n <= HL + 8), 1'b1);
        boot_done = 1'b1;
        repeat (3) @(negedge clk);
        chk("ready after boot", ready, 1'b1);
        chk("no timeout", boot_timeout, 1'b0);
        fork
            supply_partner_model_i.pin_pulse(HL);
            begin
                repeat (6) @(negedge clk);
                chk("ready drops in reset", ready, 1'b0);
            end
        join
        wait_rel(n);
        repeat (3) @(negedge clk);
        chk("ready after second boot", ready, 1'b1);
        $display("test supply dip done");
    endtask

    initial
    begin
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        t_por();
        t_boot(1'b0, BMIN);
        t_boot(1'b1, BMAX);
        t_dip();
        results();
    end
endmodule
`default_nettype wire
